// ---- inc/bfb_pkg.sv ----
// Constants shared by the breaker failure backup trip block.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package bfb_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int BFB_CLK_PERIOD_PS = 25000;
  localparam int BFB_TICK_TIME_PS = 1000000000;
  localparam int BFB_MS_CYCLES = BFB_TICK_TIME_PS / BFB_CLK_PERIOD_PS;
  localparam int BFB_FORCE_TIMEOUT_MIN = 5;
  localparam int BFB_FORCE_TIMEOUT_MS = BFB_FORCE_TIMEOUT_MIN * 60 * 1000;

  // ----------------------------------------------------------------
  // Widths and fixed values
  // ----------------------------------------------------------------
  localparam int BFB_OPTIME_W = 20;
  localparam int BFB_COUNT_W = 16;
  localparam int BFB_LOG_DEPTH = 8;
  localparam logic [6:0] BFB_PCT_FULL = 7'h64;
  localparam logic [1:0] BFB_SEL_FIRST = 2'h1;
  localparam logic [1:0] BFB_SEL_SECOND = 2'h2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] BFB_REG_CONFIG = 8'h00;
  localparam logic [7:0] BFB_REG_OPTIME = 8'h04;
  localparam logic [7:0] BFB_REG_UNLOCK = 8'h08;
  localparam logic [7:0] BFB_REG_FORCE = 8'h0C;
  localparam logic [7:0] BFB_REG_STATUS = 8'h10;
  localparam logic [7:0] BFB_REG_START_COUNT = 8'h14;
  localparam logic [7:0] BFB_REG_TRIP_COUNT = 8'h18;
  localparam logic [7:0] BFB_REG_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] BFB_REG_IRQ_MASK = 8'h20;
  localparam logic [7:0] BFB_REG_LOG_SELECT = 8'h24;
  localparam logic [7:0] BFB_REG_LOG_DATE = 8'h28;
  localparam logic [7:0] BFB_REG_LOG_TIME = 8'h2C;
  localparam logic [7:0] BFB_REG_LOG_PCT = 8'h30;
  localparam logic [7:0] BFB_REG_LOG_COUNT = 8'h34;

  // ----------------------------------------------------------------
  // Reset values and interrupt bits
  // ----------------------------------------------------------------
  localparam logic [1:0] BFB_RST_SELECT = 2'h1;
  localparam logic [BFB_OPTIME_W-1:0] BFB_RST_OPTIME = 20'h000C8;
  localparam int BFB_IRQ_START = 0;
  localparam int BFB_IRQ_TRIP = 1;
  localparam int BFB_IRQ_RELEASE = 2;
  localparam int BFB_IRQ_FORCE_END = 3;
  localparam int BFB_IRQ_W = 4;

  typedef enum logic [1:0] {BFB_IDLE, BFB_BLOCKED, BFB_STARTED, BFB_TRIPPED} bfb_state_t;

endpackage

// ---- hw/bfb_event_counter.sv ----
// Clearable saturating event counter.
// Assumes one-cycle increment and clear pulses in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module bfb_event_counter import bfb_pkg::*; #(
  parameter int WIDTH = BFB_COUNT_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic increment,
  input wire logic clear,
  // Value
  output logic [WIDTH-1:0] count
);

  // ----------------------------------------------------------------
  // Counter; an event in the clear cycle still counts
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (clear) begin
      count <= increment ? WIDTH'(1) : '0; // [R8]
    end else if (increment && count != '1) begin
      count <= count + WIDTH'(1); // [R8]
    end
  end

endmodule
`default_nettype wire

// ---- hw/bfb_fault_log.sv ----
// Ring of the latest fault records: date, time of day, elapsed percent.
// Assumes a one-cycle write pulse; read index 0 is the newest record.
`timescale 1ns/1ps
`default_nettype none
module bfb_fault_log import bfb_pkg::*; #(
  parameter int DEPTH = BFB_LOG_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Write side
  input wire logic write,
  input wire logic [31:0] writeDate,
  input wire logic [31:0] writeTime,
  input wire logic [6:0] writePct,
  // Read side
  input wire logic [$clog2(DEPTH)-1:0] readIndex,
  output logic [31:0] readDate,
  output logic [31:0] readTime,
  output logic [6:0] readPct,
  output logic [$clog2(DEPTH):0] fill
);

  localparam int AW = $clog2(DEPTH);

  logic [31:0] dateMem [DEPTH];
  logic [31:0] timeMem [DEPTH];
  logic [6:0] pctMem [DEPTH];
  logic [AW-1:0] head;
  logic [AW-1:0] readSlot;

  // ----------------------------------------------------------------
  // Storage; the oldest slot is overwritten
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      head <= '0;
      fill <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        dateMem[i] <= '0;
        timeMem[i] <= '0;
        pctMem[i] <= '0;
      end
    end else if (write) begin
      dateMem[head] <= writeDate; // [R11]
      timeMem[head] <= writeTime; // [R11]
      pctMem[head] <= writePct; // [R12]
      head <= head + AW'(1); // [R10]
      if (fill != (AW+1)'(DEPTH)) begin
        fill <= fill + (AW+1)'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Read relative to the newest record
  // ----------------------------------------------------------------
  assign readSlot = head - AW'(1) - readIndex;
  assign readDate = dateMem[readSlot];
  assign readTime = timeMem[readSlot];
  assign readPct = pctMem[readSlot];

endmodule
`default_nettype wire

// ---- hw/bfb_top.sv ----
// Breaker failure supervision stage with APB registers and interrupt.
// Assumes relay drive, block and calendar inputs synchronous to sys_clk.
//
// Function
// [R1] The drive signal of the chosen primary trip relay is watched and its asserted time measured.
// [R2] If it stays asserted beyond the operating time, a separate backup trip output is raised.
// [R3] The backup trip holds while the primary drive is active and drops when it releases.
// [R4] Only the relay drive is watched, so any protection function routed to it is covered.
// [R5] Selector value 1 watches the first trip relay, value 2 the second trip relay.
// [R6] Status shows blocked, started or tripped; start and trip can be forced only while forcing is on.
// [R7] The force flag is one common flag and clears itself after five minutes.
// [R8] Start and trip events are counted and each count can be cleared to zero.
// [R9] Operating time and force flag accept writes only while access is unlocked.
// [R10] The latest eight fault records are kept, the oldest dropped first.
// [R11] Each record holds date and time of day with millisecond resolution.
// [R12] Each record holds elapsed delay as percent of operating time, 100 meaning tripped; under 100 ms operating time the code logs elapsed ms.
// [R13] While blocked the stage neither times nor trips and its timer is cleared; a forced trip still sets stageTrip, only backupTrip is held off.
`timescale 1ns/1ps
`default_nettype none
module bfb_top import bfb_pkg::*; #(
  parameter int MS_CYCLES = BFB_MS_CYCLES,
  parameter int FORCE_MS = BFB_FORCE_TIMEOUT_MS,
  // Arbitrary unlock value
  parameter logic [31:0] UNLOCK_KEY = 32'h5A5A1234
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supervised relay drives
  input wire logic firstTripRelay,
  input wire logic secondTripRelay,
  input wire logic blockIn,
  // Calendar
  input wire logic [31:0] rtcDate,
  input wire logic [31:0] rtcTime,
  // Stage outputs
  output logic backupTrip,
  output logic stageStart,
  output logic stageTrip,
  output logic stageBlocked,
  output logic irq
);

  localparam int TW = BFB_OPTIME_W;
  localparam int PW = $clog2(MS_CYCLES);
  localparam int FW = $clog2(FORCE_MS + 1);

  bfb_state_t state;
  bfb_state_t next_state;
  logic [1:0] relaySelect;
  logic blockStage;
  logic [TW-1:0] opTime;
  logic unlocked;
  logic forceFlag;
  logic forceStart;
  logic forceTrip;
  logic [FW-1:0] forceLeft;
  logic [PW-1:0] prescale;
  logic msTick;
  logic [TW-1:0] elapsedMs;
  logic [TW:0] pctAcc;
  logic [6:0] pctNow;
  logic [BFB_IRQ_W-1:0] irqStatus;
  logic [BFB_IRQ_W-1:0] irqMask;
  logic [BFB_IRQ_W-1:0] irqEvents;
  logic [2:0] logSelect;
  logic supervised;
  logic blocked;
  logic accessPhase;
  logic wrEn;
  logic addrHit;
  logic [31:0] readMux;
  logic startPulse;
  logic tripPulse;
  logic releasePulse;
  logic forceEnd;
  logic logWrite;
  logic [6:0] logPct;
  logic [BFB_COUNT_W-1:0] startCount;
  logic [BFB_COUNT_W-1:0] tripCount;
  logic [31:0] logDate;
  logic [31:0] logTime;
  logic [6:0] logPctRead;
  logic [3:0] logFill;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign accessPhase = psel & penable & ~pready;
  assign wrEn = psel & penable & pwrite & pready & addrHit;

  always_comb begin
    addrHit = 1'b1;
    readMux = 32'h0;
    unique case (paddr)
      BFB_REG_CONFIG: readMux = {29'h0, blockStage, relaySelect};
      BFB_REG_OPTIME: readMux = {{(32-TW){1'b0}}, opTime};
      BFB_REG_UNLOCK: readMux = {31'h0, unlocked};
      BFB_REG_FORCE: readMux = {29'h0, forceTrip, forceStart, forceFlag};
      BFB_REG_STATUS: readMux = {27'h0, backupTrip, stageTrip, stageStart, stageBlocked, supervised};
      BFB_REG_START_COUNT: readMux = {{(32-BFB_COUNT_W){1'b0}}, startCount};
      BFB_REG_TRIP_COUNT: readMux = {{(32-BFB_COUNT_W){1'b0}}, tripCount};
      BFB_REG_IRQ_STATUS: readMux = {{(32-BFB_IRQ_W){1'b0}}, irqStatus};
      BFB_REG_IRQ_MASK: readMux = {{(32-BFB_IRQ_W){1'b0}}, irqMask};
      BFB_REG_LOG_SELECT: readMux = {29'h0, logSelect};
      BFB_REG_LOG_DATE: readMux = logDate;
      BFB_REG_LOG_TIME: readMux = logTime;
      BFB_REG_LOG_PCT: readMux = {25'h0, logPctRead};
      BFB_REG_LOG_COUNT: readMux = {28'h0, logFill};
      default: addrHit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= accessPhase;
      pslverr <= accessPhase & ~addrHit;
      prdata <= (accessPhase & ~pwrite) ? readMux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      relaySelect <= BFB_RST_SELECT;
      blockStage <= 1'b0;
      irqMask <= '0;
      logSelect <= 3'h0;
    end else if (wrEn) begin
      if (paddr == BFB_REG_CONFIG) begin
        relaySelect <= pwdata[1:0]; // [R5]
        blockStage <= pwdata[2];
      end
      if (paddr == BFB_REG_IRQ_MASK) begin
        irqMask <= pwdata[BFB_IRQ_W-1:0];
      end
      if (paddr == BFB_REG_LOG_SELECT) begin
        logSelect <= pwdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Access lock and protected operating time
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      unlocked <= 1'b0;
    end else if (wrEn && paddr == BFB_REG_UNLOCK) begin
      unlocked <= (pwdata == UNLOCK_KEY);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      opTime <= BFB_RST_OPTIME;
    end else if (wrEn && paddr == BFB_REG_OPTIME && unlocked) begin
      opTime <= pwdata[TW-1:0]; // [R9]
    end
  end

  // ----------------------------------------------------------------
  // Common force flag with timeout
  // ----------------------------------------------------------------
  assign forceEnd = forceFlag & msTick & (forceLeft == FW'(1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      forceFlag <= 1'b0;
      forceLeft <= '0;
    end else if (wrEn && paddr == BFB_REG_FORCE && unlocked) begin
      forceFlag <= pwdata[0]; // [R9]
      forceLeft <= FW'(FORCE_MS); // [R7]
    end else if (forceFlag && msTick) begin
      forceLeft <= forceLeft - FW'(1);
      if (forceLeft == FW'(1)) begin
        forceFlag <= 1'b0; // [R7]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      forceStart <= 1'b0;
      forceTrip <= 1'b0;
    end else if (!forceFlag) begin
      forceStart <= 1'b0;
      forceTrip <= 1'b0;
    end else if (wrEn && paddr == BFB_REG_FORCE) begin
      forceStart <= pwdata[1]; // [R6]
      forceTrip <= pwdata[2]; // [R6]
    end
  end

  // ----------------------------------------------------------------
  // Relay selection and millisecond time base
  // ----------------------------------------------------------------
  assign supervised = (relaySelect == BFB_SEL_SECOND) ? secondTripRelay : firstTripRelay; // [R4] [R5]
  assign blocked = blockIn | blockStage;
  assign msTick = (prescale == PW'(MS_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= '0;
    end else if (msTick || (forceFlag == 1'b0 && state != BFB_STARTED)) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + PW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Supervision state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      BFB_BLOCKED: begin
        if (!blocked) begin
          next_state = BFB_IDLE;
        end
      end
      BFB_IDLE: begin
        if (blocked) begin
          next_state = BFB_BLOCKED; // [R13]
        end else if (supervised) begin
          next_state = BFB_STARTED; // [R1]
        end
      end
      BFB_STARTED: begin
        if (blocked) begin
          next_state = BFB_BLOCKED; // [R13]
        end else if (!supervised) begin
          next_state = BFB_IDLE;
        end else if (elapsedMs >= opTime) begin
          next_state = BFB_TRIPPED; // [R2]
        end
      end
      BFB_TRIPPED: begin
        if (blocked) begin
          next_state = BFB_BLOCKED; // [R13]
        end else if (!supervised) begin
          next_state = BFB_IDLE; // [R3]
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= BFB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign startPulse = (state == BFB_IDLE) && (next_state == BFB_STARTED);
  assign tripPulse = (state == BFB_STARTED) && (next_state == BFB_TRIPPED);
  assign releasePulse = (state == BFB_STARTED) && (next_state == BFB_IDLE);

  // ----------------------------------------------------------------
  // Elapsed time and percentage of operating time
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      elapsedMs <= '0;
      pctAcc <= '0;
      pctNow <= 7'h0;
    end else if (state != BFB_STARTED) begin
      elapsedMs <= '0; // [R13]
      pctAcc <= '0;
      pctNow <= 7'h0;
    end else if (msTick) begin
      elapsedMs <= (elapsedMs == '1) ? elapsedMs : elapsedMs + TW'(1); // [R1]
      if (pctAcc + (TW+1)'(BFB_PCT_FULL) >= {1'b0, opTime} && pctNow < BFB_PCT_FULL) begin
        pctAcc <= pctAcc + (TW+1)'(BFB_PCT_FULL) - {1'b0, opTime}; // [R12]
        pctNow <= pctNow + 7'h1;
      end else begin
        pctAcc <= pctAcc + (TW+1)'(BFB_PCT_FULL);
      end
    end
  end

  // ----------------------------------------------------------------
  // Stage outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      backupTrip <= 1'b0;
      stageStart <= 1'b0;
      stageTrip <= 1'b0;
      stageBlocked <= 1'b0;
    end else begin
      backupTrip <= (next_state == BFB_TRIPPED) || (forceFlag && forceTrip && !blocked); // [R2] [R3] [R13]
      stageStart <= (next_state == BFB_STARTED) || (next_state == BFB_TRIPPED) || (forceFlag && forceStart); // [R6]
      stageTrip <= (next_state == BFB_TRIPPED) || (forceFlag && forceTrip); // [R6]
      stageBlocked <= (next_state == BFB_BLOCKED); // [R6]
    end
  end

  // ----------------------------------------------------------------
  // Counters and fault log
  // ----------------------------------------------------------------
  bfb_event_counter #(.WIDTH(BFB_COUNT_W)) startCounter (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .increment(startPulse),
    .clear(wrEn && paddr == BFB_REG_START_COUNT), // [R8]
    .count(startCount)
  );

  bfb_event_counter #(.WIDTH(BFB_COUNT_W)) tripCounter (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .increment(tripPulse),
    .clear(wrEn && paddr == BFB_REG_TRIP_COUNT), // [R8]
    .count(tripCount)
  );

  assign logWrite = tripPulse | releasePulse; // [R10]
  assign logPct = tripPulse ? BFB_PCT_FULL : pctNow; // [R12]

  bfb_fault_log #(.DEPTH(BFB_LOG_DEPTH)) faultLog (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .write(logWrite),
    .writeDate(rtcDate), // [R11]
    .writeTime(rtcTime), // [R11]
    .writePct(logPct),
    .readIndex(logSelect),
    .readDate(logDate),
    .readTime(logTime),
    .readPct(logPctRead),
    .fill(logFill)
  );

  // ----------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  assign irqEvents = {forceEnd, releasePulse, tripPulse, startPulse};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus <= '0;
    end else if (wrEn && paddr == BFB_REG_IRQ_STATUS) begin
      irqStatus <= (irqStatus & ~pwdata[BFB_IRQ_W-1:0]) | irqEvents;
    end else begin
      irqStatus <= irqStatus | irqEvents;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

endmodule
`default_nettype wire

// ---- sim/bfb_monitor.sv ----
// Checker for the breaker failure backup trip block.
// Assumes it is bound to bfb_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bfb_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Stage
  input wire logic firstTripRelay,
  input wire logic secondTripRelay,
  input wire logic backupTrip,
  input wire logic stageStart,
  input wire logic stageTrip,
  input wire logic stageBlocked
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("Ready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("Ready without access");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("Read data outside ready");
  err_in_ready_a: assert property (pslverr |-> pready)
    else $error("Error without ready");
  trip_after_start_a: assert property ($rose(stageTrip) |-> $past(stageStart))
    else $error("Trip without prior start");
  backup_needs_trip_a: assert property (backupTrip |-> stageTrip && stageStart)
    else $error("Backup trip outside trip state");
  blocked_quiet_a: assert property (stageBlocked && $past(stageBlocked) |-> !backupTrip && !stageTrip)
    else $error("Trip while blocked");
  backup_release_a: assert property (backupTrip && !firstTripRelay && !secondTripRelay |=> !backupTrip)
    else $error("Backup trip held after release");
  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  trip_c: cover property ($rose(backupTrip));
  err_c: cover property (pslverr);
  block_c: cover property (stageBlocked);
endmodule
`default_nettype wire

// ---- sim/bfb_relay_model.sv ----
// Protection stages driving the two supervised trip relays.
// Assumes level commands from the bench, one per relay.
`timescale 1ns/1ps
`default_nettype none
module bfb_relay_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Stage commands routed to each relay
  input wire logic [1:0] stageCmd,
  // Relay drives
  output logic firstTripRelay,
  output logic secondTripRelay
);
  // Relay drive is whatever stage is routed to it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      firstTripRelay <= 1'b0;
      secondTripRelay <= 1'b0;
    end else begin
      firstTripRelay <= stageCmd[0];
      secondTripRelay <= stageCmd[1];
    end
  end
endmodule
`default_nettype wire

// ---- sim/test_bfb_top.sv ----
// Self-checking bench of the breaker failure backup trip block.
// Assumes bfb_pkg, the design, the checker and relay model compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_bfb_top import bfb_pkg::*; ;
  localparam int MSC = 4;
  localparam int FMS = 5;
  // Arbitrary unlock value
  localparam logic [31:0] KEY = 32'h5A5A1234;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, blockIn = 0, err;
  logic [1:0] stageCmd = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rtcDate = 0, rtcTime = 0, q, prdata;
  logic pready, pslverr, firstTripRelay, secondTripRelay, backupTrip, stageStart, stageTrip, stageBlocked, irq;
  int miscompares = 0, n_checks = 0, opt, n;
  initial forever #12.5 sys_clk = ~sys_clk;
  bfb_top #(.MS_CYCLES(MSC), .FORCE_MS(FMS), .UNLOCK_KEY(KEY)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .firstTripRelay(firstTripRelay), .secondTripRelay(secondTripRelay),
    .blockIn(blockIn), .rtcDate(rtcDate), .rtcTime(rtcTime), .backupTrip(backupTrip), .stageStart(stageStart),
    .stageTrip(stageTrip), .stageBlocked(stageBlocked), .irq(irq));
  bfb_relay_model drv_u (.sys_clk(sys_clk), .reset_n(reset_n), .stageCmd(stageCmd),
    .firstTripRelay(firstTripRelay), .secondTripRelay(secondTripRelay));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask
  task automatic pulse(input logic [1:0] c, input int len);
    @(posedge sys_clk);
    stageCmd <= c;
    repeat (len) @(posedge sys_clk);
    stageCmd <= 2'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end
  initial begin
    void'($urandom(46692));
    rtcDate = $urandom;
    rtcTime = $urandom;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd("config", BFB_REG_CONFIG, 32'h1);
    apb(1'b1, BFB_REG_OPTIME, 32'h3);
    rd("locked optime", BFB_REG_OPTIME, 32'hC8);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, BFB_REG_UNLOCK, KEY);
    opt = 2 + $urandom % 4;
    apb(1'b1, BFB_REG_OPTIME, opt);
    rd("optime", BFB_REG_OPTIME, opt);
    for (int s = 1; s <= 2; s++) begin
      apb(1'b1, BFB_REG_CONFIG, s);
      stageCmd <= 2'(3 - s);
      repeat (opt * MSC + 8) @(posedge sys_clk);
      chk("other relay", {stageStart, backupTrip}, 32'h0);
      stageCmd <= 2'(s);
      n = 0;
      while (backupTrip !== 1'b1 && n < 1000) begin
        @(posedge sys_clk);
        n++;
      end
      chk("trip delay", n >= opt * MSC && n <= opt * MSC + 5, 32'h1);
      repeat (20) @(posedge sys_clk);
      chk("backup hold", backupTrip, 32'h1);
      stageCmd <= 2'h0;
      repeat (3) @(posedge sys_clk);
      chk("backup drop", backupTrip, 32'h0);
      rd("log pct", BFB_REG_LOG_PCT, 32'h64);
      rd("log time", BFB_REG_LOG_TIME, rtcTime);
    end
    rd("starts", BFB_REG_START_COUNT, 32'h2);
    rd("trips", BFB_REG_TRIP_COUNT, 32'h2);
    apb(1'b1, BFB_REG_TRIP_COUNT, 32'h0);
    rd("trips cleared", BFB_REG_TRIP_COUNT, 32'h0);
    rd("irq status", BFB_REG_IRQ_STATUS, 32'h3);
    chk("irq masked", irq, 32'h0);
    apb(1'b1, BFB_REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("irq raised", irq, 32'h1);
    apb(1'b1, BFB_REG_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", irq, 32'h0);
    pulse(2'h2, opt * MSC / 2);
    apb(1'b0, BFB_REG_LOG_PCT, 32'h0);
    chk("short pct", q < 32'h64, 32'h1);
    rd("release irq", BFB_REG_IRQ_STATUS, 32'h5);
    for (int i = 0; i < 9; i++) begin
      rtcDate <= i;
      pulse(2'h2, 2);
    end
    rd("log count", BFB_REG_LOG_COUNT, 32'h8);
    rd("newest date", BFB_REG_LOG_DATE, 32'h8);
    apb(1'b1, BFB_REG_LOG_SELECT, 32'h7);
    rd("oldest date", BFB_REG_LOG_DATE, 32'h1);
    blockIn <= 1'b1;
    stageCmd <= 2'h2;
    repeat (opt * MSC + 10) @(posedge sys_clk);
    chk("blocked", {stageBlocked, stageStart, backupTrip}, 32'h4);
    stageCmd <= 2'h0;
    blockIn <= 1'b0;
    apb(1'b1, BFB_REG_FORCE, 32'h1);
    apb(1'b1, BFB_REG_FORCE, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk("forced start", stageStart, 32'h1);
    repeat (FMS * MSC + 20) @(posedge sys_clk);
    apb(1'b0, BFB_REG_FORCE, 32'h0);
    chk("force expired", q[0], 32'h0);
    apb(1'b0, BFB_REG_IRQ_STATUS, 32'h0);
    chk("force irq", q[BFB_IRQ_FORCE_END], 32'h1);
    apb(1'b1, BFB_REG_FORCE, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("force refused", stageStart, 32'h0);
    close_out();
  end
endmodule
bind bfb_top bfb_monitor mon_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .firstTripRelay(firstTripRelay),
  .secondTripRelay(secondTripRelay), .backupTrip(backupTrip), .stageStart(stageStart), .stageTrip(stageTrip),
  .stageBlocked(stageBlocked));
`default_nettype wire
